// >>> rtl/outside_master_auto_ack_en_ack.sv
`timescale 1ns/10ps
module exmaa_ack
   import exmaa_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Outside master bus, synchronous to clk_i
   input  wire logic              xfer_start_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              dir_read_i,
   input  wire logic [SIZE_W-1:0] xfer_size_i,
   // Region decode of the captured address
   input  wire logic              cs_region_hit_i,
   input  wire logic              dram_region_hit_i,
   // Default memory control settings
   input  wire logic              outside_master_auto_ack_en_i,
   input  wire logic [WAIT_W-1:0] wait_state_count_i,
   // Captured transfer attributes
   output logic [ADDR_W-1:0]      addr_cap_o,
   output logic                   dir_read_cap_o,
   output logic [SIZE_W-1:0]      xfer_size_cap_o,
   // Transfer acknowledge pin
   output logic                   xfer_ack_n_o,
   output logic                   xfer_ack_oe_n_o
);

   // Sequencer and counter state
   exmaa_state_t      state_ff;      // Current phase
   exmaa_state_t      nxt_state;
   logic [WAIT_W-1:0] cnt_ff;        // Wait clocks still to run
   logic [WAIT_W-1:0] nxt_cnt;
   // Captured attributes
   logic [ADDR_W-1:0] addr_ff;
   logic [ADDR_W-1:0] nxt_addr;
   logic              dir_ff;
   logic              nxt_dir;
   logic [SIZE_W-1:0] size_ff;
   logic [SIZE_W-1:0] nxt_size;
   // Registered pin drive
   logic              ack_n_ff;
   logic              nxt_ack_n;
   logic              oe_n_ff;
   logic              nxt_oe_n;

   // Default memory is the fallback when no other region claims it
   logic              auto_dflt;
   assign auto_dflt = outside_master_auto_ack_en_i
                    & ~cs_region_hit_i & ~dram_region_hit_i;

   // Next state of the sequencer and the captured attributes
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_addr  = addr_ff;
      nxt_dir   = dir_ff;
      nxt_size  = size_ff;
      case (state_ff)
         ST_IDLE, ST_NEGATE: begin
            // New start may be taken in the negate clock itself, before the release
            if (!xfer_start_n_i) begin
               nxt_addr  = addr_i;
               nxt_dir   = dir_read_i;
               nxt_size  = xfer_size_i;
               nxt_state = ST_DECODE;
            end else begin
               nxt_state = ST_IDLE;
            end
         end
         ST_DECODE: begin
            // Counter only starts after the decode clock
            if (!auto_dflt) begin
               nxt_state = ST_IDLE;
            end else if (wait_state_count_i == WAIT_ZERO) begin
               nxt_state = ST_ACK;
            end else begin
               nxt_cnt   = wait_state_count_i;
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Last wait clock hands over to the acknowledge
            if (cnt_ff == WAIT_ONE) begin
               nxt_state = ST_ACK;
            end
            nxt_cnt = cnt_ff - WAIT_ONE;
         end
         ST_ACK: begin
            // Single transfers end on the first acknowledge
            nxt_state = ST_NEGATE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Pin drive follows the phase being entered, so it is a flop output
   always_comb begin
      nxt_ack_n = ACK_OFF;
      nxt_oe_n  = OE_FLOAT;
      case (nxt_state)
         ST_WAIT: begin
            nxt_oe_n = OE_DRIVE;
         end
         ST_ACK: begin
            nxt_ack_n = ACK_ON;
            nxt_oe_n  = OE_DRIVE;
         end
         ST_NEGATE: begin
            nxt_oe_n = OE_DRIVE;
         end
         default: begin
            // Idle and decode leave the line to a pull-up
            nxt_oe_n = OE_FLOAT;
         end
      endcase
   end

   // Register everything
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= CNT_RST;
         addr_ff  <= ADDR_RST;
         dir_ff   <= DIR_RST;
         size_ff  <= SIZE_RST;
         ack_n_ff <= ACK_OFF;
         oe_n_ff  <= OE_FLOAT;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         addr_ff  <= nxt_addr;
         dir_ff   <= nxt_dir;
         size_ff  <= nxt_size;
         ack_n_ff <= nxt_ack_n;
         oe_n_ff  <= nxt_oe_n;
      end
   end

   // Outputs straight from flops
   assign addr_cap_o      = addr_ff;
   assign dir_read_cap_o  = dir_ff;
   assign xfer_size_cap_o = size_ff;
   assign xfer_ack_n_o    = ack_n_ff;
   assign xfer_ack_oe_n_o = oe_n_ff;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   logic take_start;
   logic dec_auto;
   assign take_start = (state_ff == ST_IDLE) && !xfer_start_n_i;
   assign dec_auto   = (state_ff == ST_DECODE) && auto_dflt;

   property p_decode_gap;
      take_start |=> state_ff == ST_DECODE && xfer_ack_oe_n_o ##1
                     state_ff != ST_DECODE;
   endproperty
   a_decode_gap: assert property (p_decode_gap)
      else $error("decode clock not inserted after start");

   property p_capture;
      take_start |=> addr_cap_o == $past(addr_i)
                  && dir_read_cap_o == $past(dir_read_i)
                  && xfer_size_cap_o == $past(xfer_size_i);
   endproperty
   a_capture: assert property (p_capture)
      else $error("attributes not captured at start");

   property p_load_count;
      dec_auto && wait_state_count_i != WAIT_ZERO
         |=> cnt_ff == $past(wait_state_count_i);
   endproperty
   a_load_count: assert property (p_load_count)
      else $error("wait count not loaded");

   property p_zero_wait;
      dec_auto && wait_state_count_i == WAIT_ZERO
         |=> !xfer_ack_n_o && !xfer_ack_oe_n_o;
   endproperty
   a_zero_wait: assert property (p_zero_wait)
      else $error("no acknowledge at third clock");

   property p_wait_driven;
      state_ff == ST_WAIT |-> xfer_ack_n_o && !xfer_ack_oe_n_o;
   endproperty
   a_wait_driven: assert property (p_wait_driven)
      else $error("acknowledge not driven inactive in wait");

   property p_release;
      !xfer_ack_n_o |=> (xfer_ack_n_o && !xfer_ack_oe_n_o) ##1
                         xfer_ack_oe_n_o;
   endproperty
   a_release: assert property (p_release)
      else $error("acknowledge not negated then released");

   property p_two_waits;
      dec_auto && wait_state_count_i == 4'h2
         |=> xfer_ack_n_o [*2] ##1 !xfer_ack_n_o;
   endproperty
   a_two_waits: assert property (p_two_waits)
      else $error("acknowledge not after programmed waits");

   property p_other_region;
      state_ff == ST_DECODE && (cs_region_hit_i || dram_region_hit_i)
         |=> xfer_ack_oe_n_o && state_ff == ST_IDLE;
   endproperty
   a_other_region: assert property (p_other_region)
      else $error("default settings used in other region");

   property p_count_end;
      state_ff == ST_WAIT && cnt_ff == WAIT_ONE |=> !xfer_ack_n_o;
   endproperty
   a_count_end: assert property (p_count_end)
      else $error("counter end gave no acknowledge");

   property p_no_auto;
      state_ff == ST_DECODE && !outside_master_auto_ack_en_i
         |-> xfer_ack_oe_n_o ##1 xfer_ack_oe_n_o;
   endproperty
   a_no_auto: assert property (p_no_auto)
      else $error("acknowledge driven with auto-ack off");

   // Main scenarios
   c_zero_wait: cover property (dec_auto && wait_state_count_i == WAIT_ZERO);
   c_waited: cover property (state_ff == ST_WAIT ##1 state_ff == ST_ACK);
   c_no_auto: cover property (state_ff == ST_DECODE && !auto_dflt);
   c_back2back: cover property (state_ff == ST_NEGATE && !xfer_start_n_i);

endmodule : exmaa_ack

// >>> rtl/outside_master_auto_ack_en_pkg.sv
package exmaa_pkg;

   // Bus widths
   localparam int ADDR_W = 28;                 // Outside master address
   localparam int SIZE_W = 2;                  // Transfer size code
   localparam int WAIT_W = 4;                  // Wait-state field width

   // Values after reset
   localparam logic [ADDR_W-1:0] ADDR_RST = 28'h0000000;
   localparam logic [SIZE_W-1:0] SIZE_RST = 2'h0;
   localparam logic              DIR_RST  = 1'b0;
   localparam logic [WAIT_W-1:0] CNT_RST  = 4'h0;
   localparam logic              ACK_OFF  = 1'b1; // Acknowledge negated
   localparam logic              ACK_ON   = 1'b0; // Acknowledge asserted
   localparam logic              OE_DRIVE = 1'b0; // Pin driven
   localparam logic              OE_FLOAT = 1'b1; // Pin released

   // Counter compare points
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
   localparam logic [WAIT_W-1:0] WAIT_ONE  = 4'h1;

   // Transfer sequencer, one-hot
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,  // Watching for transfer start
      ST_DECODE = 5'h02,  // Extra decode clock
      ST_WAIT   = 5'h04,  // Counting wait states, ack negated
      ST_ACK    = 5'h08,  // Acknowledge asserted
      ST_NEGATE = 5'h10   // Ack driven inactive before release
   } exmaa_state_t;

endpackage : exmaa_pkg

// >>> testbench/outside_master_auto_ack_en_master.sv
`timescale 1ns/10ps
// Outside bus master model, single transfers only
module exmaa_master
   import exmaa_pkg::*;
(
   // Clock and resolved acknowledge wire
   input  wire logic              clk_i,
   input  wire logic              ack_w_i,
   // Master bus outputs
   output logic                   xfer_start_n_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic                   dir_read_o,
   output logic [SIZE_W-1:0]      xfer_size_o,
   output logic [31:0]            data_o
);
   // Idle bus levels at time zero
   initial begin
      xfer_start_n_o = 1'b1;
      addr_o         = 28'h0000000;
      dir_read_o     = 1'b1;
      xfer_size_o    = 2'h0;
      data_o         = 32'h00000000;
   end

   // One transfer; lat is edges after start release, -1 if never acked.
   // now starts in the current clock (back to back), chain keeps the
   // address so that a following transfer can take the lines at once
   task automatic xfer(input logic [ADDR_W-1:0] a, input logic rd,
                       input logic [SIZE_W-1:0] s, input logic [31:0] d,
                       input bit now, input bit chain, output int lat);
      lat = -1;
      if (!now) @(posedge clk_i);
      xfer_start_n_o <= 1'b0;
      addr_o         <= a;
      dir_read_o     <= rd;
      xfer_size_o    <= s;
      @(posedge clk_i);
      xfer_start_n_o <= 1'b1;
      if (!rd) data_o <= d;
      // Bounded so a silent slave cannot hang us
      for (int n = 1; n <= 20 && lat < 0; n++) begin
         @(posedge clk_i);
         if (ack_w_i === 1'b0) lat = n;
      end
      // Released lines show a changed pattern, not stale values
      if (!chain) addr_o <= ~a;
      data_o <= ~data_o;
   endtask : xfer
endmodule : exmaa_master

// >>> testbench/outside_master_auto_ack_en_ack_tb.sv
`timescale 1ns/10ps
module exmaa_ack_tb
   import exmaa_pkg::*;
;
   logic              clk, nrst, cs_hit, dram_hit, en;
   logic [WAIT_W-1:0] wcnt;
   logic              start_n, dir, ack_n, oe_n;
   logic [ADDR_W-1:0] addr, addr_cap;
   logic [SIZE_W-1:0] size, size_cap;
   logic              dir_cap;
   wire               ack_w = oe_n ? 1'b1 : ack_n; // Pull-up when released
   int                failures = 0;
   int                checked = 0;
   int                oe_cnt = 0;   // Cycles the ack pin was driven

   exmaa_ack dut_u (.clk_i(clk), .nrst_i(nrst), .xfer_start_n_i(start_n),
      .addr_i(addr), .dir_read_i(dir), .xfer_size_i(size),
      .cs_region_hit_i(cs_hit), .dram_region_hit_i(dram_hit),
      .outside_master_auto_ack_en_i(en), .wait_state_count_i(wcnt),
      .addr_cap_o(addr_cap), .dir_read_cap_o(dir_cap),
      .xfer_size_cap_o(size_cap), .xfer_ack_n_o(ack_n),
      .xfer_ack_oe_n_o(oe_n));
   exmaa_master mst_u (.clk_i(clk), .ack_w_i(ack_w),
      .xfer_start_n_o(start_n), .addr_o(addr), .dir_read_o(dir),
      .xfer_size_o(size), .data_o());

   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Drive-time monitor sees pre-edge values
   always @(posedge clk) if (oe_n === 1'b0) oe_cnt <= oe_cnt + 1;

   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk

   // One transfer with settings, judged against expectations
   task automatic run(logic [ADDR_W-1:0] a, logic rd, logic [SIZE_W-1:0] s,
                      logic [WAIT_W-1:0] w, logic e, logic c, logic d);
      int  lat;
      int  oe0;
      logic hit;
      hit = e & ~c & ~d;
      @(posedge clk);
      en <= e;
      wcnt <= w;
      cs_hit <= c;
      dram_hit <= d;
      oe0 = oe_cnt;
      mst_u.xfer(a, rd, s, 32'h5A5AC3C3, 1'b0, 1'b0, lat);
      #1;
      // Ack seen at the second edge after start release, plus the waits
      chk("latency", hit ? 32'(w) + 32'h2 : 32'hFFFFFFFF, 32'(lat));
      chk("neg drive", {31'h0, hit ? 1'b0 : 1'b1}, {31'h0, oe_n});
      chk("neg level", 32'h1, {31'h0, ack_n});
      @(posedge clk);
      #1;
      chk("release", 32'h1, {31'h0, oe_n});
      chk("driven cycles", hit ? 32'(w) + 32'h2 : 32'h0, 32'(oe_cnt - oe0));
      chk("addr cap", {4'h0, a}, {4'h0, addr_cap});
      chk("dir cap", {31'h0, rd}, {31'h0, dir_cap});
      chk("size cap", {30'h0, s}, {30'h0, size_cap});
   endtask : run

   task automatic t_zero_wait();
      for (int i = 0; i < 4; i++)
         run(28'hABCDEF0 + 28'(i), i[0], 2'(i), 4'h0, 1'b1, 1'b0, 1'b0);
      $display("test zero_wait done");
   endtask : t_zero_wait
   task automatic t_waits();
      run(28'h0000004, 1'b0, 2'h1, 4'h2, 1'b1, 1'b0, 1'b0);
      run(28'hFFFFFFC, 1'b1, 2'h2, 4'hF, 1'b1, 1'b0, 1'b0);
      $display("test waits done");
   endtask : t_waits
   task automatic t_no_ack();
      run(28'h1234560, 1'b1, 2'h0, 4'h0, 1'b0, 1'b0, 1'b0);
      run(28'h0F0F0F0, 1'b0, 2'h3, 4'h1, 1'b1, 1'b1, 1'b0);
      run(28'h7070700, 1'b1, 2'h1, 4'h0, 1'b1, 1'b0, 1'b1);
      $display("test no_ack done");
   endtask : t_no_ack
   // Second start lands in the clock where ack is driven negated
   task automatic t_back2back();
      int lat1;
      int lat2;
      @(posedge clk);
      en       <= 1'b1;
      wcnt     <= 4'h1;
      cs_hit   <= 1'b0;
      dram_hit <= 1'b0;
      mst_u.xfer(28'h0000010, 1'b0, 2'h0, 32'h1234ABCD, 1'b0, 1'b1, lat1);
      mst_u.xfer(28'h0000020, 1'b1, 2'h2, 32'h00000000, 1'b1, 1'b0, lat2);
      #1;
      chk("b2b first latency", 32'h3, 32'(lat1));
      chk("b2b second latency", 32'h3, 32'(lat2));
      chk("b2b addr cap", 32'h0000020, {4'h0, addr_cap});
      chk("b2b size cap", 32'h2, {30'h0, size_cap});
      chk("b2b neg level", 32'h1, {31'h0, ack_n});
      @(posedge clk);
      #1;
      chk("b2b release", 32'h1, {31'h0, oe_n});
      $display("test back2back done");
   endtask : t_back2back

   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim

   // Watchdog, far beyond the roughly 150 cycles needed
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_sim();
   end
   // Main sequence
   initial begin
      nrst = 1'b0;
      en = 1'b0;
      wcnt = 4'h0;
      cs_hit = 1'b0;
      dram_hit = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_zero_wait();
      t_waits();
      t_no_ack();
      t_back2back();
      end_sim();
   end
endmodule : exmaa_ack_tb
